// ---- hdl/sbs_pkg.sv ----
// constants and helpers shared by both ends of the split-port burst sram link
// assumes one common clock and reset for both ends
//
// Summary of operation
// - write data taken on every beat of a write
// - write data bus 9, 18 or 36 bits
// - active-low write select starts write on K phase
// - deselected write port ignores write data
// - nibble enables gate bits 3:0 and 7:4
// - nibble enable sampled with its own beat
// - active-low byte enables sampled with each beat
// - disabled byte lanes keep previous contents
// - byte enables gate 8:0, 17:9, 26:18, 35:27
// - one address bus shared, sampled on K phase
// - address 21, 20 or 19 bits per width
// - address ignored when port deselected
// - read data launched on every beat
// - read outputs released once a four-beat burst ends with read deselected
// - read bus width per organisation, requested data only
// - every access begins on K phase
// - every read delivers four beats
package sbs_pkg;
    // ========================================================
    // organisation widths
    localparam int DW_X9      = 9;
    localparam int DW_X18     = 18;
    localparam int DW_X36     = 36;
    localparam int AW_X9      = 21;
    localparam int AW_X18     = 20;
    localparam int AW_X36     = 19;
    // the built link is the widest organisation
    localparam int DW         = DW_X36;
    localparam int AW         = AW_X36;
    localparam int NBE        = 4;
    localparam int LANE_W     = 9;
    localparam int NIB_W      = 4;
    localparam int NNIB       = 2;
    // ========================================================
    // burst and model depth
    localparam int BURST      = 4;
    localparam int BEAT_W     = 2;
    localparam int MEM_GBITS  = 4;
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_W     = AW + NBE + DW;
    // ========================================================
    // reset values
    localparam logic       PHASE_RST = 1'b0;
    localparam logic [DW-1:0] Q_RST  = 36'h0;

    // per-bit write mask from the active-low lane enables
    function automatic logic [DW-1:0] lane_mask(
        input logic [NBE-1:0] be_n,
        input logic           nibble_mode
    );
        logic [DW-1:0] m;
        m = '0;
        if (nibble_mode) begin
            for (int n = 0; n < NNIB; n++) begin
                if (!be_n[n]) begin
                    m[n*NIB_W +: NIB_W] = '1;
                end
            end
        end else begin
            for (int b = 0; b < NBE; b++) begin
                if (!be_n[b]) begin
                    m[b*LANE_W +: LANE_W] = '1;
                end
            end
        end
        return m;
    endfunction
endpackage

// ---- hdl/sbs_link_if.sv ----
// pin bundle between memory device end and controller end
// assumes both ends share i_clock; q is valid only while q_oe is high
`timescale 1ns/100ps
`default_nettype none
interface sbs_link_if;
    logic                     write_port_select_n;
    logic                     read_port_select_n;
    logic [sbs_pkg::AW-1:0]   addr;
    logic [sbs_pkg::DW-1:0]   d;
    logic [sbs_pkg::NBE-1:0]  byte_write_enable_n;
    logic [sbs_pkg::DW-1:0]   q;
    logic                     q_oe;

    modport device (
        input  write_port_select_n,
        input  read_port_select_n,
        input  addr,
        input  d,
        input  byte_write_enable_n,
        output q,
        output q_oe
    );
    modport ctrl (
        output write_port_select_n,
        output read_port_select_n,
        output addr,
        output d,
        output byte_write_enable_n,
        input  q,
        input  q_oe
    );
endinterface
`default_nettype wire

// ---- hdl/sbs_fifo.sv ----
// small synchronous fifo with valid/ready on both sides
// assumes a single clock; depth is a power of two
`timescale 1ns/100ps
`default_nettype none
module sbs_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 8
) (
    input  wire logic         i_clock,
    input  wire logic         i_rst_n,
    input  wire logic [W-1:0] i_in_data,
    input  wire logic         i_in_valid,
    output logic              o_in_ready,
    output logic [W-1:0]      o_out_data,
    output logic              o_out_valid,
    input  wire logic         i_out_ready
);
    localparam int PW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [PW:0]  wr_q;
    logic [PW:0]  rd_q;
    logic         push;
    logic         pop;

    // ========================================================
    // flags
    assign o_in_ready  = (wr_q - rd_q) != (PW+1)'(DEPTH);
    assign o_out_valid = wr_q != rd_q;
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;
    assign o_out_data  = mem[rd_q[PW-1:0]];

    // ========================================================
    // storage and pointers
    always_ff @(posedge i_clock) begin
        if (push) begin
            mem[wr_q[PW-1:0]] <= i_in_data;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ---- hdl/sbs_device.sv ----
// memory device end: separate burst read and write ports on one address bus
// assumes the controller resets with it so both phase toggles agree
`timescale 1ns/100ps
`default_nettype none
module sbs_device (
    input  wire logic   i_clock,
    input  wire logic   i_rst_n,
    input  wire logic   i_nibble_mode,
    sbs_link_if.device  link
);
    localparam int MW = sbs_pkg::MEM_GBITS + sbs_pkg::BEAT_W;
    // small model array; upper address bits are not decoded
    logic [sbs_pkg::DW-1:0]        mem [2**MW];
    logic                          phase_q;
    logic                          wbusy_q;
    logic [sbs_pkg::BEAT_W-1:0]    wbeat_q;
    logic [sbs_pkg::MEM_GBITS-1:0] waddr_q;
    logic [sbs_pkg::BEAT_W-1:0]    rbeat_q;
    logic [sbs_pkg::MEM_GBITS-1:0] raddr_q;
    logic [sbs_pkg::DW-1:0]        q_q;
    logic                          oe_q;
    logic                          wr_start;
    logic                          rd_start;
    logic                          wr_en;
    logic [MW-1:0]                 wr_idx;
    logic [sbs_pkg::DW-1:0]        wmask;

    // ========================================================
    // phase: 0 is the K rising edge, 1 the K-bar edge
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            phase_q <= sbs_pkg::PHASE_RST;
        end else begin
            phase_q <= ~phase_q;
        end
    end

    // ========================================================
    // write port
    assign wr_start = !phase_q && !wbusy_q
                      && !link.write_port_select_n;
    assign wr_en    = wr_start || wbusy_q;
    // first beat uses the bus address, later beats the held one
    assign wr_idx   = wr_start
                      ? {link.addr[sbs_pkg::MEM_GBITS-1:0],
                         sbs_pkg::BEAT_W'(0)}
                      : {waddr_q, wbeat_q};
    assign wmask    = sbs_pkg::lane_mask(link.byte_write_enable_n,
                                         i_nibble_mode);

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wbusy_q <= 1'b0;
            wbeat_q <= '0;
            waddr_q <= '0;
        end else if (wr_start) begin
            wbusy_q <= 1'b1;
            wbeat_q <= sbs_pkg::BEAT_W'(1);
            waddr_q <= link.addr[sbs_pkg::MEM_GBITS-1:0];
        end else if (wbusy_q) begin
            wbeat_q <= wbeat_q + 1'b1;
            if (wbeat_q == sbs_pkg::BEAT_W'(sbs_pkg::BURST - 1)) begin
                wbusy_q <= 1'b0;
            end
        end
    end

    // only enabled lanes change; others keep what they held
    always_ff @(posedge i_clock) begin
        if (wr_en) begin
            mem[wr_idx] <= (mem[wr_idx] & ~wmask)
                           | (link.d & wmask);
        end
    end

    // ========================================================
    // read port: beat 0 appears the cycle after the select
    assign rd_start = !phase_q && !link.read_port_select_n
                      && (!oe_q || rbeat_q == sbs_pkg::BEAT_W'(
                          sbs_pkg::BURST - 1));

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            oe_q    <= 1'b0;
            rbeat_q <= '0;
            raddr_q <= '0;
        end else if (rd_start) begin
            oe_q    <= 1'b1;
            rbeat_q <= '0;
            raddr_q <= link.addr[sbs_pkg::MEM_GBITS-1:0];
        end else if (oe_q) begin
            if (rbeat_q == sbs_pkg::BEAT_W'(sbs_pkg::BURST - 1)) begin
                oe_q <= 1'b0;
            end else begin
                rbeat_q <= rbeat_q + 1'b1;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q_q <= sbs_pkg::Q_RST;
        end else if (rd_start) begin
            q_q <= mem[{link.addr[sbs_pkg::MEM_GBITS-1:0],
                        sbs_pkg::BEAT_W'(0)}];
        end else if (oe_q && rbeat_q != sbs_pkg::BEAT_W'(
                     sbs_pkg::BURST - 1)) begin
            q_q <= mem[{raddr_q, rbeat_q + 1'b1}];
        end else begin
            q_q <= sbs_pkg::Q_RST;
        end
    end

    assign link.q    = q_q;
    assign link.q_oe = oe_q;
endmodule
`default_nettype wire

// ---- hdl/sbs_ctrl.sv ----
// controller end: queues write beats, issues four-beat bursts, collects reads
// assumes the device resets with it so both phase toggles agree
`timescale 1ns/100ps
`default_nettype none
module sbs_ctrl (
    input  wire logic                      i_clock,
    input  wire logic                      i_rst_n,
    input  wire logic [sbs_pkg::AW-1:0]    i_wr_addr,
    input  wire logic [sbs_pkg::DW-1:0]    i_wr_data,
    input  wire logic [sbs_pkg::NBE-1:0]   i_wr_be_n,
    input  wire logic                      i_wr_valid,
    output logic                           o_wr_ready,
    input  wire logic [sbs_pkg::AW-1:0]    i_rd_addr,
    input  wire logic                      i_rd_valid,
    output logic                           o_rd_ready,
    output logic [sbs_pkg::DW-1:0]         o_rd_data,
    output logic                           o_rd_valid,
    sbs_link_if.ctrl                       link
);
    typedef enum logic [1:0] {
        SBS_WR_IDLE  = 2'b01,
        SBS_WR_BURST = 2'b10
    } sbs_wr_st_t;

    sbs_wr_st_t                 st_q;
    logic                       phase_q;
    logic [sbs_pkg::BEAT_W-1:0] wcnt_q;
    logic [sbs_pkg::BEAT_W-1:0] rcnt_q;
    logic [sbs_pkg::FIFO_W-1:0] f_data;
    logic                       f_valid;
    logic                       f_pop;
    logic                       rd_go;
    logic                       wr_go;
    logic                       wps_n_q;
    logic                       rps_n_q;
    logic [sbs_pkg::AW-1:0]     addr_q;
    logic [sbs_pkg::DW-1:0]     d_q;
    logic [sbs_pkg::NBE-1:0]    be_n_q;

    // ========================================================
    // write beat queue; full fifo stalls the user
    sbs_fifo #(
        .W     (sbs_pkg::FIFO_W),
        .DEPTH (sbs_pkg::FIFO_DEPTH)
    ) u_fifo (
        .i_clock     (i_clock),
        .i_rst_n     (i_rst_n),
        .i_in_data   ({i_wr_addr, i_wr_be_n, i_wr_data}),
        .i_in_valid  (i_wr_valid),
        .o_in_ready  (o_wr_ready),
        .o_out_data  (f_data),
        .o_out_valid (f_valid),
        .i_out_ready (f_pop)
    );

    // ========================================================
    // decisions on phase 1 so registered pins land on K phase
    assign o_rd_ready = phase_q && rcnt_q == '0;
    assign rd_go      = o_rd_ready && i_rd_valid;
    // reads win the shared address when both are ready on one cycle
    assign wr_go      = phase_q && !rd_go && f_valid
                        && st_q == SBS_WR_IDLE;
    assign f_pop      = wr_go || (st_q == SBS_WR_BURST && f_valid);

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            phase_q <= sbs_pkg::PHASE_RST;
        end else begin
            phase_q <= ~phase_q;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rcnt_q <= '0;
        end else if (rd_go) begin
            rcnt_q <= sbs_pkg::BEAT_W'(sbs_pkg::BURST - 1);
        end else if (rcnt_q != '0) begin
            rcnt_q <= rcnt_q - 1'b1;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q   <= SBS_WR_IDLE;
            wcnt_q <= '0;
        end else begin
            case (st_q)
                SBS_WR_IDLE: begin
                    if (wr_go) begin
                        st_q   <= SBS_WR_BURST;
                        wcnt_q <= sbs_pkg::BEAT_W'(1);
                    end
                end
                SBS_WR_BURST: begin
                    wcnt_q <= wcnt_q + 1'b1;
                    if (wcnt_q == sbs_pkg::BEAT_W'(sbs_pkg::BURST - 1)) begin
                        st_q <= SBS_WR_IDLE;
                    end
                end
                default: begin
                    st_q <= SBS_WR_IDLE;
                end
            endcase
        end
    end

    // ========================================================
    // pin registers
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wps_n_q <= 1'b1;
            rps_n_q <= 1'b1;
            addr_q  <= '0;
            d_q     <= '0;
            be_n_q  <= '1;
        end else begin
            wps_n_q <= !wr_go;
            rps_n_q <= !rd_go;
            if (rd_go) begin
                addr_q <= i_rd_addr;
            end else if (wr_go) begin
                addr_q <= f_data[sbs_pkg::FIFO_W-1 -: sbs_pkg::AW];
            end
            if (f_pop) begin
                d_q    <= f_data[sbs_pkg::DW-1:0];
                be_n_q <= f_data[sbs_pkg::DW +: sbs_pkg::NBE];
            end else begin
                // an underrun beat is sent with every lane disabled
                be_n_q <= '1;
            end
        end
    end

    assign link.write_port_select_n = wps_n_q;
    assign link.read_port_select_n  = rps_n_q;
    assign link.addr                = addr_q;
    assign link.d                   = d_q;
    assign link.byte_write_enable_n = be_n_q;

    // ========================================================
    // read capture
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rd_data  <= '0;
            o_rd_valid <= 1'b0;
        end else begin
            o_rd_valid <= link.q_oe;
            if (link.q_oe) begin
                o_rd_data <= link.q;
            end
        end
    end
endmodule
`default_nettype wire

// ---- tb/sbs_link_properties.sv ----
// link checker: pin timing between controller end and device end
// assumes one clock and one reset shared by both ends
`timescale 1ns/100ps
`default_nettype none
module sbs_link_properties (
    input wire logic                    i_clock,
    input wire logic                    i_rst_n,
    input wire logic                    write_port_select_n,
    input wire logic                    read_port_select_n,
    input wire logic [sbs_pkg::AW-1:0]  addr,
    input wire logic [sbs_pkg::DW-1:0]  d,
    input wire logic [sbs_pkg::NBE-1:0] byte_write_enable_n,
    input wire logic [sbs_pkg::DW-1:0]  q,
    input wire logic                    q_oe
);
    // ====================
    // phase helper, even cycles after release are K phase
    logic ph_q;
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ph_q <= 1'b0;
        end else begin
            ph_q <= ~ph_q;
        end
    end
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_n);
    // ====================
    // assertions
    a_wsel_k_phase:
        assert property (!write_port_select_n |-> !ph_q)
        else $error("write select off K phase");
    a_rsel_k_phase:
        assert property (!read_port_select_n |-> !ph_q)
        else $error("read select off K phase");
    a_wsel_spacing:
        assert property (!write_port_select_n |=> write_port_select_n[*3])
        else $error("write select inside a burst");
    a_rsel_spacing:
        assert property (!read_port_select_n |=> read_port_select_n[*3])
        else $error("read select inside a burst");
    a_read_four_beats:
        assert property (!read_port_select_n |=> q_oe[*4])
        else $error("read burst shorter than four");
    a_q_oe_cause:
        assert property ($rose(q_oe) |-> $past(!read_port_select_n))
        else $error("output enable without read");
    a_q_oe_idle:
        assert property (read_port_select_n[*4] |=> !q_oe)
        else $error("output enable after deselect");
    a_q_zero_idle:
        assert property (!q_oe |-> q == '0)
        else $error("read data while released");
    a_wsel_idle_lanes:
        assert property (write_port_select_n[*4] |->
                         byte_write_enable_n == '1 && $stable(d))
        else $error("write lanes active while deselected");
    a_addr_hold:
        assert property (write_port_select_n && read_port_select_n
                         |-> $stable(addr))
        else $error("address moved with both ports idle");
endmodule
`default_nettype wire

// ---- tb/test_split_port_burst_sram_pins.sv ----
// bench: controller and device joined on one link, and a second
// device in nibble mode driven by the bench directly
// assumes a 10 MHz clock and active-low asynchronous reset
`timescale 1ns/100ps
`default_nettype none
module test_split_port_burst_sram_pins;
    logic                    clock, rst_n, wr_valid, wr_ready;
    logic [sbs_pkg::AW-1:0]  wr_addr, rd_addr;
    logic [sbs_pkg::DW-1:0]  wr_data, rd_data;
    logic [sbs_pkg::NBE-1:0] wr_be_n;
    logic                    rd_req, rd_ready, rd_vld;
    logic [35:0]             ex [4], da [4], db [4];
    logic [3:0]              bm [4], nm [4], bz [4];
    int                      bad_count, n_tests, cyc;
    sbs_link_if link();
    sbs_link_if link2();
    // ====================
    // instances
    sbs_device i_sbs_device (.i_clock(clock), .i_rst_n(rst_n),
        .i_nibble_mode(1'b0), .link(link));
    // the second device faces the bench, which breaks the rules on it
    sbs_device i_sbs_device_2 (.i_clock(clock), .i_rst_n(rst_n),
        .i_nibble_mode(1'b1), .link(link2));
    sbs_ctrl i_sbs_ctrl (.i_clock(clock), .i_rst_n(rst_n),
        .i_wr_addr(wr_addr), .i_wr_data(wr_data), .i_wr_be_n(wr_be_n),
        .i_wr_valid(wr_valid), .o_wr_ready(wr_ready),
        .i_rd_addr(rd_addr), .i_rd_valid(rd_req), .o_rd_ready(rd_ready),
        .o_rd_data(rd_data), .o_rd_valid(rd_vld), .link(link));
    sbs_link_properties i_sbs_link_properties (.i_clock(clock),
        .i_rst_n(rst_n),
        .write_port_select_n(link.write_port_select_n),
        .read_port_select_n(link.read_port_select_n),
        .addr(link.addr), .d(link.d),
        .byte_write_enable_n(link.byte_write_enable_n),
        .q(link.q), .q_oe(link.q_oe));
    initial clock = 1'b0;
    always #50 clock = ~clock;
    // cyc holds the index of the next edge, read between edges only
    always @(posedge clock) cyc <= rst_n ? cyc + 1 : 0;
    // ====================
    // tasks
    task automatic chk36(input logic [35:0] got, input logic [35:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    function automatic logic [35:0] merge(input logic [35:0] o, n,
                                          input logic [3:0] be);
        merge = o;
        for (int l = 0; l < 4; l++) begin
            if (!be[l]) merge[l*9 +: 9] = n[l*9 +: 9];
        end
    endfunction
    task automatic wr1(input logic [18:0] a, input logic [35:0] v,
                       input logic [3:0] be);
        wr_addr  <= a;
        wr_data  <= v;
        wr_be_n  <= be;
        wr_valid <= 1'b1;
        // ready is looked at between edges, never in the edge's own step
        @(negedge clock);
        chk1(wr_ready, 1'b1);
        @(posedge clock);
    endtask
    task automatic rd1(input logic [18:0] a);
        rd_addr <= a;
        rd_req  <= 1'b1;
        @(negedge clock);
        for (int t = 0; t < 40 && rd_ready !== 1'b1; t++)
            @(negedge clock);
        @(posedge clock);
        rd_req <= 1'b0;
        for (int b = 0; b < 4; b++) begin
            @(negedge clock);
            for (int t = 0; t < 20 && rd_vld !== 1'b1; t++)
                @(negedge clock);
            chk36(rd_data, ex[b]);
        end
        @(negedge clock);
        chk1(rd_vld, 1'b0);
        @(posedge clock);
    endtask
    // leaves the bench just after the edge before a K phase edge
    task automatic kalign;
        @(negedge clock);
        while (cyc[0] !== 1'b1)
            @(negedge clock);
        @(posedge clock);
    endtask
    task automatic wr2(input logic [18:0] a, input logic [35:0] v [4],
                       input logic [3:0] m [4], input logic odd);
        kalign();
        if (odd) @(posedge clock);
        for (int k = 0; k < 4; k++) begin
            link2.write_port_select_n <= (k != 0);
            link2.addr                <= (k == 0) ? a : ~a;
            link2.d                   <= v[k];
            link2.byte_write_enable_n <= m[k];
            @(posedge clock);
        end
        link2.write_port_select_n <= 1'b1;
        link2.d                   <= ~v[3];
        link2.byte_write_enable_n <= 4'hF;
    endtask
    task automatic rd2(input logic [18:0] a);
        kalign();
        link2.read_port_select_n <= 1'b0;
        link2.addr               <= a;
        @(posedge clock);
        link2.read_port_select_n <= 1'b1;
        link2.addr               <= ~a;
        for (int b = 0; b < 4; b++) begin
            @(negedge clock);
            chk1(link2.q_oe, 1'b1);
            chk36({28'h0, link2.q[7:0]}, ex[b]);
        end
        @(negedge clock);
        chk1(link2.q_oe, 1'b0);
        chk36(link2.q, 36'h0);
        @(posedge clock);
    endtask
    // ====================
    // tests
    initial begin
        rst_n = 1'b0;
        {wr_addr, wr_data, wr_valid, rd_addr, rd_req} = '0;
        wr_be_n = 4'hF;
        link2.write_port_select_n = 1'b1;
        link2.read_port_select_n  = 1'b1;
        link2.addr                = '0;
        link2.d                   = '0;
        link2.byte_write_enable_n = 4'hF;
        for (int k = 0; k < 4; k++) begin
            da[k] = {4{9'h0A5 + 9'(k)}};
            db[k] = {4{9'h15A ^ 9'(k * 3)}};
        end
        bm = '{4'h6, 4'hF, 4'h9, 4'h0};
        nm = '{4'hE, 4'hD, 4'hF, 4'hC};
        bz = '{default: 4'h0};
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        chk36(36'($bits(link.d)), 36'(sbs_pkg::DW_X36));
        chk36(36'($bits(link.addr)), 36'(sbs_pkg::AW_X36));
        for (int k = 0; k < 4; k++)
            wr1(19'h3, da[k], 4'h0);
        wr_valid <= 1'b0;
        repeat (12) @(posedge clock);
        ex = da;
        rd1(19'h3);
        for (int k = 0; k < 4; k++)
            wr1(19'h3, db[k], bm[k]);
        wr_valid <= 1'b0;
        repeat (12) @(posedge clock);
        for (int k = 0; k < 4; k++)
            ex[k] = merge(da[k], db[k], bm[k]);
        rd1(19'h3);
        wr2(19'h1, da, bz, 1'b0);
        wr2(19'h1, db, bz, 1'b1);
        wr2(19'h1, db, nm, 1'b0);
        for (int k = 0; k < 4; k++) begin
            ex[k] = {28'h0, da[k][7:0]};
            if (!nm[k][0]) ex[k][3:0] = db[k][3:0];
            if (!nm[k][1]) ex[k][7:4] = db[k][7:4];
        end
        rd2(19'h1);
        // write queue through the controller: eight beats back to back,
        // the fifth beat opens the second group with its own address
        for (int k = 0; k < 4; k++)
            wr1(19'h5, da[k], 4'h0);
        for (int k = 0; k < 4; k++)
            wr1(19'h6, db[k], 4'h0);
        wr_valid <= 1'b0;
        repeat (12) @(posedge clock);
        ex = da;
        rd1(19'h5);
        ex = db;
        rd1(19'h6);
        print_verdict();
    end
    // watchdog, some twenty-five times the expected run
    initial begin
        #(3000 * 100);
        bad_count++;
        print_verdict();
    end
endmodule
`default_nettype wire
